// ===== hw/mem_bank_cfg_regs.vh
// Field widths, defaults and timing figures for the external memory bank block
`ifndef MEM_BANK_CFG_REGS_VH
`define MEM_BANK_CFG_REGS_VH
`define NUM_BANKS 4
`define LAUNCH_W 2
`define LAUNCH_RST 2'h0
`define PERIOD_W 12
`define PERIOD_RST 12'h000
`define RAS_HIGH_W 5
`define COL_LOW_W 4
`define STRENGTH_W 2
`define QUAL_W 2
`define QUAL_READ 2'h1
`define QUAL_WRITE 2'h2
`define QUAL_BOTH 2'h3
`define QUAL_NONE 2'h0
`define STROBE_N 3
`define ROW_W 16
`define ROW_CYC 4'h2
`define COL_CYC 4'h2
`define PAD_LOW_LSB 0
`define PAD_TWO_LSB 2
`define PAD_THREE_LSB 4
`define PAD_FOUR_LSB 6
`define PAD_FIVE_LSB 8
`define PAD_HIGH_LSB 10
`define PAD_LANE1_LSB 12
`define QUAL_STRIDE 6
`define QUAL_COL_LSB 0
`define QUAL_PS_LSB 2
`define QUAL_WS_LSB 4
`endif

// ===== hw/ext_mem_bank_ctrl.v
// External memory bank sequencer with refresh, strobes and pad strengths
// Contract
// - Delay write data launch from column start
// - Launch delay counts half-cycle phases 0..3
// - Non-DRAM banks never receive refresh
// - DRAM access uses row then column phase
// - Page mode skips row for same row
// - Refresh bank only if enabled and period nonzero
// - Refresh spacing programmable 0..4095 cycles
// - Zero period issues no refresh
// - Refresh row strobe high for phases
// - Column strobe low for refresh time
// - Qualifier gates column strobe falls by type
// - Default both, write strobe write-only
// - Inactive strobe never asserted; refresh still drives column strobe low on refreshed banks
// - Strength fields two bits, 0..3
// - Seven pad groups with own fields
// - Four banks, independent settings
// - Phase equals half a clock cycle
`timescale 1ns/10ps
`include "mem_bank_cfg_regs.vh"
module ext_mem_bank_ctrl #(
    parameter NB = `NUM_BANKS,
    parameter RW = `ROW_W
) (
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    input wire [NB-1:0] bank_is_dram,
    input wire [NB-1:0] same_row_reuse_enable,
    input wire [NB-1:0] bank_refresh_enable,
    input wire [2*NB-1:0] write_data_launch_delay,
    input wire [3*2*NB-1:0] strobe_qualifier,
    input wire [11:0] refresh_period_count,
    input wire [4:0] refresh_row_strobe_high_time,
    input wire [3:0] refresh_column_low_time,
    input wire [13:0] pad_strength_config,
    input wire req_valid,
    input wire req_write,
    input wire [1:0] req_bank,
    input wire [RW-1:0] req_row,
    output reg req_ready,
    output reg done,
    output reg [NB-1:0] row_strobe_n,
    output reg [NB-1:0] column_strobe_n,
    output reg [NB-1:0] prog_strobe_n,
    output reg write_strobe_n,
    output reg data_oe_n,
    output reg refresh_busy,
    output reg [1:0] addr_low_group_strength,
    output reg [1:0] addr_group_two_strength,
    output reg [1:0] addr_group_three_strength,
    output reg [1:0] addr_group_four_strength,
    output reg [1:0] addr_group_five_strength,
    output reg [1:0] addr_high_group_strength,
    output reg [1:0] byte_lane1_strength
);
    localparam S_IDLE = 5'b00001;
    localparam S_ROW = 5'b00010;
    localparam S_COL = 5'b00100;
    localparam S_REF = 5'b01000;
    localparam S_END = 5'b10000;

    reg rs1_q, rs2_q;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    wire rst_i_n = rs2_q;

    reg [4:0] st_q;
    reg [5:0] ph_q;
    reg [11:0] tmr_q;
    reg ref_pend_q;
    reg [1:0] bank_q;
    reg wr_q;
    reg [NB-1:0] open_q;
    reg [RW*NB-1:0] row_q;
    reg [NB-1:0] ref_mask_q;

    wire [1:0] dly = write_data_launch_delay[2*bank_q +: 2];
    // phase counter steps by two per clock
    wire [5:0] ph_next = ph_q + 6'h02;
    wire [5:0] ref_ph = {1'b0, refresh_column_low_time, 1'b0};
    wire [5:0] row_ph = {1'b0, `ROW_CYC, 1'b0};
    wire [5:0] col_ph = {1'b0, `COL_CYC, 1'b0};
    wire period_on = |refresh_period_count;
    // Expiry in the cycle a request is taken keeps the new one posted
    wire tmr_exp = period_on && (tmr_q >= refresh_period_count - 12'h001);
    wire [5:0] qual_bank =
        strobe_qualifier[`QUAL_STRIDE*bank_q +: `QUAL_STRIDE];
    wire hit = open_q[req_bank] && same_row_reuse_enable[req_bank] &&
        (row_q[RW*req_bank +: RW] == req_row);

    // strobe fall qualification per bank and type
    function qual_ok;
        input [1:0] q;
        input w;
        begin
            qual_ok = w ? q[1] : q[0];
        end
    endfunction

    integer i;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            ph_q <= 6'h00;
            tmr_q <= `PERIOD_RST;
            ref_pend_q <= 1'b0;
            bank_q <= 2'h0;
            wr_q <= 1'b0;
            open_q <= {NB{1'b0}};
            row_q <= {RW*NB{1'b0}};
            ref_mask_q <= {NB{1'b0}};
            req_ready <= 1'b0;
            done <= 1'b0;
            row_strobe_n <= {NB{1'b1}};
            column_strobe_n <= {NB{1'b1}};
            prog_strobe_n <= {NB{1'b1}};
            write_strobe_n <= 1'b1;
            data_oe_n <= 1'b1;
            refresh_busy <= 1'b0;
            addr_low_group_strength <= 2'h0;
            addr_group_two_strength <= 2'h0;
            addr_group_three_strength <= 2'h0;
            addr_group_four_strength <= 2'h0;
            addr_group_five_strength <= 2'h0;
            addr_high_group_strength <= 2'h0;
            byte_lane1_strength <= 2'h0;
        end else if (!rst_i_n) begin
            st_q <= S_IDLE;
        end else if (clk_en) begin
            addr_low_group_strength <=
                pad_strength_config[`PAD_LOW_LSB +: `STRENGTH_W];
            addr_group_two_strength <=
                pad_strength_config[`PAD_TWO_LSB +: `STRENGTH_W];
            addr_group_three_strength <=
                pad_strength_config[`PAD_THREE_LSB +: `STRENGTH_W];
            addr_group_four_strength <=
                pad_strength_config[`PAD_FOUR_LSB +: `STRENGTH_W];
            addr_group_five_strength <=
                pad_strength_config[`PAD_FIVE_LSB +: `STRENGTH_W];
            addr_high_group_strength <=
                pad_strength_config[`PAD_HIGH_LSB +: `STRENGTH_W];
            byte_lane1_strength <=
                pad_strength_config[`PAD_LANE1_LSB +: `STRENGTH_W];
            done <= 1'b0;
            if (!period_on) begin
                tmr_q <= `PERIOD_RST;
                ref_pend_q <= 1'b0;
            end else if (tmr_exp) begin
                tmr_q <= 12'h000;
                ref_pend_q <= 1'b1;
            end else begin
                tmr_q <= tmr_q + 12'h001;
            end
            req_ready <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (ref_pend_q && period_on) begin
                        ref_mask_q <= bank_is_dram & bank_refresh_enable;
                        ref_pend_q <= tmr_exp;
                        open_q <= {NB{1'b0}};
                        refresh_busy <= 1'b1;
                        ph_q <= 6'h00;
                        st_q <= S_REF;
                    end else if (req_valid) begin
                        req_ready <= 1'b1;
                        bank_q <= req_bank;
                        wr_q <= req_write;
                        ph_q <= 6'h00;
                        if (bank_is_dram[req_bank] && !hit) begin
                            st_q <= S_ROW;
                        end else begin
                            st_q <= S_COL;
                        end
                        if (bank_is_dram[req_bank]) begin
                            open_q[req_bank] <= 1'b1;
                            row_q[RW*req_bank +: RW] <= req_row;
                        end
                    end
                end
                S_ROW: begin
                    row_strobe_n[bank_q] <= 1'b0;
                    ph_q <= ph_next;
                    if (ph_next >= row_ph) begin
                        ph_q <= 6'h00;
                        st_q <= S_COL;
                    end
                end
                S_COL: begin
                    if (bank_is_dram[bank_q])
                        row_strobe_n[bank_q] <= 1'b0;
                    column_strobe_n[bank_q] <=
                        !qual_ok(qual_bank[`QUAL_COL_LSB +: `QUAL_W], wr_q);
                    prog_strobe_n[bank_q] <=
                        !qual_ok(qual_bank[`QUAL_PS_LSB +: `QUAL_W], wr_q);
                    write_strobe_n <=
                        !qual_ok(qual_bank[`QUAL_WS_LSB +: `QUAL_W], wr_q);
                    // launch data after delay phases
                    // Odd delays round up to a whole cycle; the last column
                    // cycle is the latest launch point for write data
                    if (wr_q && ({4'h0, dly} <= ph_q || ph_next >= col_ph))
                        data_oe_n <= 1'b0;
                    ph_q <= ph_next;
                    if (ph_next >= col_ph)
                        st_q <= S_END;
                end
                S_REF: begin
                    column_strobe_n <= ~ref_mask_q;
                    // row strobe high for programmed phases
                    if ({1'b0, refresh_row_strobe_high_time} <= ph_q)
                        row_strobe_n <= ~ref_mask_q;
                    else
                        row_strobe_n <= {NB{1'b1}};
                    ph_q <= ph_next;
                    if (ph_next >= ref_ph)
                        st_q <= S_END;
                end
                default: begin
                    // Close all strobes before the next cycle
                    row_strobe_n <= {NB{1'b1}};
                    column_strobe_n <= {NB{1'b1}};
                    prog_strobe_n <= {NB{1'b1}};
                    write_strobe_n <= 1'b1;
                    data_oe_n <= 1'b1;
                    done <= ~refresh_busy;
                    refresh_busy <= 1'b0;
                    st_q <= S_IDLE;
                end
            endcase
            for (i = 0; i < NB; i = i + 1)
                if (!bank_is_dram[i])
                    open_q[i] <= 1'b0;
        end
    end
endmodule // ext_mem_bank_ctrl

// ===== dv/mem_dev_model.sv
// Memory device stand-in that notes which banks saw a refresh
`timescale 1ns/10ps
module mem_dev_model (
    input wire clk_sys,
    input wire [3:0] row_strobe_n,
    input wire [3:0] column_strobe_n,
    output reg [3:0] refreshed
);
reg [3:0] col_q = 4'hf;
initial refreshed = 4'h0;
always @(posedge clk_sys) begin
    col_q <= column_strobe_n;
    // Column falling while row is high is a refresh, not an access
    refreshed <= refreshed | (col_q & ~column_strobe_n & row_strobe_n);
end
endmodule // mem_dev_model

// ===== dv/mem_bank_chk.sv
// Checker for request, refresh, strobe and pad-strength behaviour
`timescale 1ns/10ps
module mem_bank_chk (
    input wire clk_sys,
    input wire rst_n,
    input wire [3:0] bank_is_dram,
    input wire [3:0] bank_refresh_enable,
    input wire [23:0] strobe_qualifier,
    input wire [11:0] refresh_period_count,
    input wire [13:0] pad_strength_config,
    input wire req_valid,
    input wire req_write,
    input wire req_ready,
    input wire done,
    input wire [3:0] column_strobe_n,
    input wire [3:0] prog_strobe_n,
    input wire data_oe_n,
    input wire refresh_busy,
    input wire [1:0] addr_low_group_strength,
    input wire [1:0] byte_lane1_strength
);
reg wr_q;
reg cur_wr_q;
wire [3:0] ps_on = {|strobe_qualifier[21:20], |strobe_qualifier[15:14],
    |strobe_qualifier[9:8], |strobe_qualifier[3:2]};
// Type of the access in flight, latched when it is taken
always @(posedge clk_sys) begin
    wr_q <= req_write;
    if (req_ready) cur_wr_q <= wr_q;
end
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
a_ready_pulse: assert property (req_ready |=> !req_ready)
    else $error("req_ready held over one cycle");
a_ready_cause: assert property (req_ready |-> $past(req_valid))
    else $error("req_ready without a request");
a_done_bound: assert property (req_ready |-> ##[1:6] done)
    else $error("access did not end in time");
a_done_pulse: assert property (done |=> !done)
    else $error("done held over one cycle");
a_refresh_first: assert property (refresh_busy |-> !req_ready)
    else $error("request taken during refresh");
a_zero_period: assert property ($rose(refresh_busy) |->
    refresh_period_count != 12'h000)
    else $error("refresh with zero period");
a_refresh_banks: assert property (refresh_busy |-> (~column_strobe_n &
    ~(bank_is_dram & bank_refresh_enable)) == 4'h0)
    else $error("refresh reached a disabled bank");
a_read_no_drive: assert property (!data_oe_n |-> cur_wr_q)
    else $error("data driven in a read");
a_inactive_ps: assert property ((~prog_strobe_n & ~ps_on) == 4'h0)
    else $error("inactive strobe asserted");
a_pad_map: assert property ($stable(pad_strength_config)[*4] |->
    addr_low_group_strength == pad_strength_config[1:0] &&
    byte_lane1_strength == pad_strength_config[13:12])
    else $error("pad strength mismatch");
endmodule // mem_bank_chk
bind ext_mem_bank_ctrl mem_bank_chk u_mem_bank_chk (.*);

// ===== dv/external_memory_bank_config_bench.sv
// Self-checking bench for the external memory bank sequencer
`timescale 1ns/10ps
module external_memory_bank_config_bench;
reg clk_sys = 1'b0;
reg rst_n = 1'b0;
reg [3:0] dram = 4'hf, reuse = 4'h0, ref_en = 4'hf;
reg [7:0] launch = 8'h00;
reg [23:0] qual = 24'hbefbef;
reg [11:0] period = 12'h000;
reg [13:0] pad = 14'h2d8e;
reg valid = 1'b0, wr = 1'b0;
reg [1:0] bank = 2'h0;
reg [15:0] row = 16'h0000;
wire ready, done, busy, oe_n, ws_n;
wire [3:0] ras_n, cas_n, ps_n, seen_ref;
wire [13:0] st;
integer fail_count = 0, samples_checked = 0, n_oe, n_cas, n_ws, n_len, i;
always #12.5 clk_sys = ~clk_sys;
ext_mem_bank_ctrl u_ext_mem_bank_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(1'b1), .bank_is_dram(dram), .same_row_reuse_enable(reuse),
    .bank_refresh_enable(ref_en), .write_data_launch_delay(launch),
    .strobe_qualifier(qual), .refresh_period_count(period),
    .refresh_row_strobe_high_time(5'h04), .refresh_column_low_time(4'h3),
    .pad_strength_config(pad), .req_valid(valid), .req_write(wr),
    .req_bank(bank), .req_row(row), .req_ready(ready), .done(done),
    .row_strobe_n(ras_n), .column_strobe_n(cas_n), .prog_strobe_n(ps_n),
    .write_strobe_n(ws_n), .data_oe_n(oe_n), .refresh_busy(busy),
    .addr_low_group_strength(st[1:0]), .addr_group_two_strength(st[3:2]),
    .addr_group_three_strength(st[5:4]), .addr_group_four_strength(st[7:6]),
    .addr_group_five_strength(st[9:8]),
    .addr_high_group_strength(st[11:10]), .byte_lane1_strength(st[13:12]));
mem_dev_model u_mem_dev_model (.clk_sys(clk_sys), .row_strobe_n(ras_n),
    .column_strobe_n(cas_n), .refreshed(seen_ref));
task chk(input string what, input [31:0] exp, input [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
endtask
// One access; counts strobe and drive cycles from take to done
task acc(input [1:0] b, input w, input [15:0] r);
    bank = b;
    wr = w;
    row = r;
    valid = 1'b1;
    {n_oe, n_cas, n_ws, n_len, i} = 0;
    do begin
        @(negedge clk_sys);
        i = i + 1;
    end while (ready !== 1'b1 && i < 200);
    valid = 1'b0;
    for (i = 0; i < 20 && done !== 1'b1; i = i + 1) begin
        n_cas = n_cas + !cas_n[b];
        n_oe = n_oe + !oe_n;
        n_ws = n_ws + !ws_n;
        n_len = n_len + 1;
        @(negedge clk_sys);
    end
    chk("access done", 1, done);
endtask
task t_data;
    integer oe0;
    acc(0, 1'b1, 16'h0005);
    chk("write strobe", 1, n_ws > 0);
    oe0 = n_oe;
    launch = 8'h02;
    acc(0, 1'b1, 16'h0005);
    chk("launch delay", oe0 - 1, n_oe);
    acc(0, 1'b0, 16'h0005);
    chk("read drive", 0, n_oe + n_ws);
endtask
task t_qual;
    qual[3:0] = 4'h1;
    acc(0, 1'b1, 16'h0005);
    chk("column strobe write", 0, n_cas);
    acc(0, 1'b0, 16'h0005);
    chk("column strobe read", 1, n_cas > 0);
    qual[1:0] = 2'h0;
    acc(0, 1'b0, 16'h0005);
    chk("inactive column strobe", 0, n_cas);
    qual = 24'hbefbef;
endtask
task t_page;
    integer len1;
    reuse = 4'h1;
    acc(0, 1'b0, 16'h0007);
    len1 = n_len;
    acc(0, 1'b0, 16'h0007);
    chk("page hit shorter", 1, n_len < len1);
    reuse = 4'h0;
    acc(0, 1'b0, 16'h0007);
    chk("page mode off", len1, n_len);
endtask
task t_refresh;
    n_cas = 0;
    repeat (300) @(negedge clk_sys) n_cas = n_cas + busy;
    chk("zero period refresh", 0, n_cas);
    dram = 4'hd;
    ref_en = 4'hb;
    period = 12'h028;
    for (i = 0; i < 100 && busy !== 1'b1; i = i + 1) @(negedge clk_sys);
    {n_cas, n_ws} = 0;
    repeat (30) begin
        @(negedge clk_sys);
        n_cas = n_cas + !cas_n[0];
        n_ws = n_ws + (!cas_n[0] && !ras_n[0]);
    end
    chk("refresh column low", 3, n_cas);
    chk("refresh row strobe low", 1, n_ws);
    for (i = 0; i < 100 && busy !== 1'b1; i = i + 1) @(negedge clk_sys);
    chk("refresh spacing", period, 30 + i);
    repeat (200) @(negedge clk_sys);
    chk("banks refreshed", 4'h9, seen_ref);
endtask
task give_verdict;
    $display("checks %0d failures %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("pad strengths", pad, st);
    t_data;
    t_qual;
    t_page;
    t_refresh;
    give_verdict;
end
initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count = fail_count + 1;
    give_verdict;
end
endmodule // external_memory_bank_config_bench
